// File: sbap_defines.svh
// Named constants for the system bus address phase ends.
//
// Function
// RQ1: Sub-phase one carries address bits 35:3
// RQ2: Sub-phase two carries transaction type information
// RQ3: Device samples address lines as straps in reset
// RQ4: Receiver captures on both strobe edges
// RQ5: Strobe 0: codes, bits 16:3; strobe 1: 35:17
// RQ6: Mask input forces address bit 20 low
// RQ7: Agent asserts mask only in real mode
// RQ8: Mask valid by target ready of I/O write; the hub has no I/O write, mask_out_n follows mask_req and real_mode
// RQ9: Valid strobe marks valid address and codes
// RQ10: Valid strobe starts decode and checks
// RQ11: All agents work on bus clock rising edge
// RQ12: Agent unable to accept asserts block request
// RQ13: No new transaction while block request asserted
// RQ14: Hash-marked signals are active low
`ifndef SBAP_DEFINES_SVH
`define SBAP_DEFINES_SVH

// ----------------------------------------------------------------
// Address and code fields
// ----------------------------------------------------------------
`define SBAP_ADDR_MSB   35
`define SBAP_ADDR_LSB   3
`define SBAP_G0_MSB     16
`define SBAP_G1_LSB     17
`define SBAP_CODE_MSB   4
`define SBAP_MASK_BIT   20

// ----------------------------------------------------------------
// Idle line levels (active-low lines rest high)
// ----------------------------------------------------------------
`define SBAP_STB_IDLE   2'h3
`define SBAP_LINE_IDLE  1'h1
`define SBAP_LINE_ACT   1'h0

`endif

// File: sbap_pkg.sv
// Types shared by both ends of the system bus address phase.
`default_nettype none
`include "sbap_defines.svh"
package sbap_pkg;

    // ----------------------------------------------------------------
    // Field types
    // ----------------------------------------------------------------
    typedef logic [`SBAP_ADDR_MSB:`SBAP_ADDR_LSB] sbap_addr_t;
    typedef logic [`SBAP_CODE_MSB:0]              sbap_code_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SUB1, TX_SUB2} sbap_tx_state_t;

    // ----------------------------------------------------------------
    // Processor end state
    // ----------------------------------------------------------------
    typedef struct packed {
        sbap_addr_t hold_addr;
        sbap_addr_t hold_attr;
        sbap_code_t hold_code_a;
        sbap_code_t hold_code_b;
        logic       req_tgl;
        logic       pending;
        logic       req_ready;
        logic       stall;
        sbap_addr_t strap_value;
        logic       strap_valid;
        logic       a20_active;
    } sbap_cpu_core_t;

    typedef struct packed {
        sbap_tx_state_t state;
        logic           seen_tgl;
        logic           ack_tgl;
        sbap_addr_t     addr_out_n;
        logic           addr_oe;
        sbap_code_t     code_out_n;
        logic           avs_n;
        logic [1:0]     stb_n;
        logic           bnr_out_n;
        logic           bnr_oe;
        logic           strap_done;
    } sbap_cpu_bus_t;

    // ----------------------------------------------------------------
    // Hub end state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] stb_prev;
        sbap_addr_t sub1_addr;
        sbap_addr_t sub2_addr;
        sbap_code_t sub1_code;
        sbap_code_t sub2_code;
        logic       g0_done;
        logic       g1_done;
        logic       busy;
        logic       rx_tgl;
        sbap_addr_t addr_out_n;
        logic       addr_oe;
        logic       bnr_out_n;
        logic       bnr_oe;
    } sbap_hub_bus_t;

    typedef struct packed {
        logic       rx_valid;
        sbap_addr_t rx_addr;
        sbap_addr_t rx_attr;
        sbap_code_t rx_code_a;
        sbap_code_t rx_code_b;
        logic       ack_tgl;
        logic       mask_out_n;
        logic       stall;
    } sbap_hub_core_t;

endpackage : sbap_pkg
`default_nettype wire

// File: sbap_if.sv
// Link between processor end and hub end, with wire resolution.
`timescale 1ns/1ps
`default_nettype none
`include "sbap_defines.svh"
interface sbap_if;
    import sbap_pkg::*;

    // ----------------------------------------------------------------
    // Bus clock, driven by the bench
    // ----------------------------------------------------------------
    logic       bus_clk;

    // ----------------------------------------------------------------
    // Per-end drive and resolved lines
    // ----------------------------------------------------------------
    sbap_addr_t addr_n_cpu;
    logic       addr_oe_cpu;
    sbap_addr_t addr_n_hub;
    logic       addr_oe_hub;
    sbap_addr_t addr_n;
    sbap_code_t req_code_n;
    logic       addr_valid_strobe_n;
    logic [1:0] addr_sample_strobes_n;
    logic       bnr_n_cpu;
    logic       bnr_oe_cpu;
    logic       bnr_n_hub;
    logic       bnr_oe_hub;
    logic       block_next_request_n;
    logic       addr_bit20_mask_n;

    // Pulled-up shared address lines
    assign addr_n = addr_oe_cpu ? addr_n_cpu : (addr_oe_hub ? addr_n_hub : '1);
    // Wired-low stall line, either agent may pull it
    assign block_next_request_n = ~((bnr_oe_cpu & ~bnr_n_cpu) | (bnr_oe_hub & ~bnr_n_hub));

    modport cpu (
        input  bus_clk, addr_n, block_next_request_n, addr_bit20_mask_n,
        output addr_n_cpu, addr_oe_cpu, req_code_n, addr_valid_strobe_n,
        output addr_sample_strobes_n, bnr_n_cpu, bnr_oe_cpu
    );
    modport hub (
        input  bus_clk, addr_n, req_code_n, addr_valid_strobe_n,
        input  addr_sample_strobes_n, block_next_request_n,
        output addr_n_hub, addr_oe_hub, bnr_n_hub, bnr_oe_hub, addr_bit20_mask_n
    );
endinterface : sbap_if
`default_nettype wire

// File: sbap_sync.sv
// Two-flop synchroniser, also used as a reset release synchroniser.
`timescale 1ns/1ps
`default_nettype none
module sbap_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sbap_sync
`default_nettype wire

// File: sbap_cpu_end.sv
// Processor end: request issue over the address phase, strap capture, mask.
`timescale 1ns/1ps
`default_nettype none
`include "sbap_defines.svh"
module sbap_cpu_end (
    // Core clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // Request from the core side
    input  wire logic                 req_valid,
    output var  logic                 req_ready,
    input  wire sbap_pkg::sbap_addr_t req_addr,
    input  wire sbap_pkg::sbap_addr_t req_attr,
    input  wire sbap_pkg::sbap_code_t req_code_a,
    input  wire sbap_pkg::sbap_code_t req_code_b,
    // Agent cannot accept more work
    input  wire logic                 stall_req,
    // Strap and mask status
    output var  sbap_pkg::sbap_addr_t strap_value,
    output var  logic                 strap_valid,
    output var  logic                 a20_active,
    // Link
    sbap_if.cpu                       link
);
    import sbap_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sbap_cpu_core_t core;
    sbap_cpu_core_t next_core;
    sbap_cpu_bus_t  bus;
    sbap_cpu_bus_t  next_bus;
    sbap_addr_t     straps;
    logic           bus_rst_n;
    logic [1:0]     bus_in_s;
    logic [2:0]     core_in_s;
    logic           req_tgl_s;
    logic           stall_s;
    logic           ack_s;
    logic           strap_done_s;
    logic           mask_s;

    localparam sbap_cpu_core_t CORE_RST = '{
        default: '0
    };
    localparam sbap_cpu_bus_t BUS_RST = '{
        state:      TX_IDLE,
        addr_out_n: '1,
        code_out_n: '1,
        avs_n:      `SBAP_LINE_IDLE,
        stb_n:      `SBAP_STB_IDLE,
        bnr_out_n:  `SBAP_LINE_IDLE,
        default:    '0
    };

    // ----------------------------------------------------------------
    // Crossings
    // ----------------------------------------------------------------
    // Bus-side reset: asserts at once, releases on the bus clock
    sbap_sync #(.WIDTH(1)) u_bus_rst (
        .clk    (link.bus_clk),
        .arst_n (arst_n),
        .d      (1'b1),
        .q      (bus_rst_n)
    );

    // Request toggle and stall level into the bus domain
    sbap_sync #(.WIDTH(2)) u_bus_in (
        .clk    (link.bus_clk),
        .arst_n (bus_rst_n),
        .d      ({core.req_tgl, core.stall}),
        .q      (bus_in_s)
    );

    // Ack toggle, strap-done level and asynchronous mask pin into core
    sbap_sync #(.WIDTH(3)) u_core_in (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({bus.ack_tgl, bus.strap_done, ~link.addr_bit20_mask_n}), // RQ14
        .q      (core_in_s)
    );

    assign req_tgl_s    = bus_in_s[1];
    assign stall_s      = bus_in_s[0];
    assign ack_s        = core_in_s[2];
    assign strap_done_s = core_in_s[1];
    assign mask_s       = core_in_s[0];

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Loads every bus clock while reset is held, freezes at release;
    // no reset of its own so that it can follow the lines during reset
    always_ff @(posedge link.bus_clk) begin
        if (!bus_rst_n) begin
            straps <= ~link.addr_n; // RQ3
        end
    end

    // ----------------------------------------------------------------
    // Core side: request hold, mask, strap report
    // ----------------------------------------------------------------
    // Hold fields stay still while pending, so the bus side may read them
    always_comb begin
        next_core            = core;
        next_core.stall      = stall_req;
        next_core.a20_active = mask_s;
        if (core.pending && (ack_s == core.req_tgl)) begin
            next_core.pending = 1'b0;
        end
        if (!core.pending && req_valid) begin
            next_core.hold_addr   = req_addr;
            next_core.hold_attr   = req_attr;
            next_core.hold_code_a = req_code_a;
            next_core.hold_code_b = req_code_b;
            next_core.req_tgl     = ~core.req_tgl;
            next_core.pending     = 1'b1;
            if (mask_s) begin
                next_core.hold_addr[`SBAP_MASK_BIT] = 1'b0; // RQ6
            end
        end
        next_core.req_ready = ~next_core.pending;
        // Straps are static once released, so a level flag qualifies them
        if (strap_done_s && !core.strap_valid) begin
            next_core.strap_value = straps;
            next_core.strap_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core <= CORE_RST;
        end else begin
            core <= next_core;
        end
    end

    // ----------------------------------------------------------------
    // Bus side: address phase sequencer
    // ----------------------------------------------------------------
    // Each sub-phase flips both strobes once, so the pair of sub-phases
    // gives one falling and one rising edge and leaves them idle again
    always_comb begin
        next_bus            = bus;
        next_bus.strap_done = 1'b1;
        next_bus.bnr_oe     = stall_s; // RQ12
        next_bus.bnr_out_n  = ~stall_s; // RQ14
        unique case (bus.state)
            TX_IDLE: begin
                next_bus.addr_oe    = 1'b0;
                next_bus.addr_out_n = '1;
                next_bus.code_out_n = '1;
                next_bus.avs_n      = `SBAP_LINE_IDLE;
                if ((req_tgl_s != bus.seen_tgl) &&
                    (link.block_next_request_n == `SBAP_LINE_IDLE)) begin // RQ13
                    next_bus.seen_tgl   = req_tgl_s;
                    next_bus.addr_oe    = 1'b1;
                    next_bus.addr_out_n = ~core.hold_addr; // RQ1
                    next_bus.code_out_n = ~core.hold_code_a;
                    next_bus.avs_n      = `SBAP_LINE_ACT; // RQ9
                    next_bus.stb_n      = ~bus.stb_n; // RQ5
                    next_bus.state      = TX_SUB1;
                end
            end
            TX_SUB1: begin
                next_bus.addr_out_n = ~core.hold_attr; // RQ2
                next_bus.code_out_n = ~core.hold_code_b;
                next_bus.avs_n      = `SBAP_LINE_IDLE;
                next_bus.stb_n      = ~bus.stb_n; // RQ4
                next_bus.state      = TX_SUB2;
            end
            TX_SUB2: begin
                next_bus.addr_oe    = 1'b0;
                next_bus.addr_out_n = '1;
                next_bus.code_out_n = '1;
                next_bus.ack_tgl    = bus.seen_tgl;
                next_bus.state      = TX_IDLE;
            end
            default: begin
                next_bus.state = TX_IDLE;
            end
        endcase
    end

    // Link logic runs on the bus clock rising edge
    always_ff @(posedge link.bus_clk or negedge bus_rst_n) begin
        if (!bus_rst_n) begin
            bus <= BUS_RST;
        end else begin
            bus <= next_bus; // RQ11
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all from flops
    // ----------------------------------------------------------------
    assign req_ready                  = core.req_ready;
    assign strap_value                = core.strap_value;
    assign strap_valid                = core.strap_valid;
    assign a20_active                 = core.a20_active;
    assign link.addr_n_cpu            = bus.addr_out_n;
    assign link.addr_oe_cpu           = bus.addr_oe;
    assign link.req_code_n            = bus.code_out_n;
    assign link.addr_valid_strobe_n   = bus.avs_n;
    assign link.addr_sample_strobes_n = bus.stb_n;
    assign link.bnr_n_cpu             = bus.bnr_out_n;
    assign link.bnr_oe_cpu            = bus.bnr_oe;
endmodule : sbap_cpu_end
`default_nettype wire

// File: sbap_hub_end.sv
// Hub end: address phase capture, stall signalling, strap and mask drive.
`timescale 1ns/1ps
`default_nettype none
`include "sbap_defines.svh"
module sbap_hub_end #(
    parameter sbap_pkg::sbap_addr_t STRAP_VALUE = '0
) (
    // Core clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // Received transaction
    output var  logic                 rx_valid,
    input  wire logic                 rx_ready,
    output var  sbap_pkg::sbap_addr_t rx_addr,
    output var  sbap_pkg::sbap_addr_t rx_attr,
    output var  sbap_pkg::sbap_code_t rx_code_a,
    output var  sbap_pkg::sbap_code_t rx_code_b,
    // Control
    input  wire logic                 stall_req,
    input  wire logic                 mask_req,
    input  wire logic                 real_mode,
    // Link
    sbap_if.hub                       link
);
    import sbap_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sbap_hub_bus_t  bus;
    sbap_hub_bus_t  next_bus;
    sbap_hub_core_t core;
    sbap_hub_core_t next_core;
    logic           bus_rst_n;
    logic [1:0]     bus_in_s;
    logic           rx_tgl_s;
    logic [1:0]     edge_seen;
    logic           valid_now;

    localparam sbap_hub_bus_t BUS_RST = '{
        stb_prev:   `SBAP_STB_IDLE,
        addr_out_n: ~STRAP_VALUE,
        addr_oe:    1'b1,
        bnr_out_n:  `SBAP_LINE_IDLE,
        default:    '0
    };
    localparam sbap_hub_core_t CORE_RST = '{
        mask_out_n: `SBAP_LINE_IDLE,
        default:    '0
    };

    // ----------------------------------------------------------------
    // Crossings
    // ----------------------------------------------------------------
    sbap_sync #(.WIDTH(1)) u_bus_rst (
        .clk    (link.bus_clk),
        .arst_n (arst_n),
        .d      (1'b1),
        .q      (bus_rst_n)
    );

    // Ack toggle and stall level into the bus domain
    sbap_sync #(.WIDTH(2)) u_bus_in (
        .clk    (link.bus_clk),
        .arst_n (bus_rst_n),
        .d      ({core.ack_tgl, core.stall}),
        .q      (bus_in_s)
    );

    sbap_sync #(.WIDTH(1)) u_core_in (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (bus.rx_tgl),
        .q      (rx_tgl_s)
    );

    // ----------------------------------------------------------------
    // Bus side: capture on either strobe edge
    // ----------------------------------------------------------------
    assign edge_seen = link.addr_sample_strobes_n ^ bus.stb_prev; // RQ4
    assign valid_now = (link.addr_valid_strobe_n == `SBAP_LINE_ACT); // RQ10

    // Edge with the valid strobe low is sub-phase one, the next is two;
    // the captured pair is reused, so the stall line guards it
    always_comb begin
        next_bus          = bus;
        next_bus.stb_prev = link.addr_sample_strobes_n;
        next_bus.addr_oe  = 1'b0;
        if (bus.busy && (bus_in_s[1] == bus.rx_tgl)) begin
            next_bus.busy = 1'b0;
        end
        if (edge_seen[0]) begin // RQ5
            if (valid_now) begin
                next_bus.sub1_addr[`SBAP_G0_MSB:`SBAP_ADDR_LSB] =
                    ~link.addr_n[`SBAP_G0_MSB:`SBAP_ADDR_LSB]; // RQ1
                next_bus.sub1_code = ~link.req_code_n;
                next_bus.g0_done   = 1'b0;
            end else begin
                next_bus.sub2_addr[`SBAP_G0_MSB:`SBAP_ADDR_LSB] =
                    ~link.addr_n[`SBAP_G0_MSB:`SBAP_ADDR_LSB]; // RQ2
                next_bus.sub2_code = ~link.req_code_n;
                next_bus.g0_done   = 1'b1;
            end
        end
        if (edge_seen[1]) begin // RQ5
            if (valid_now) begin
                next_bus.sub1_addr[`SBAP_ADDR_MSB:`SBAP_G1_LSB] =
                    ~link.addr_n[`SBAP_ADDR_MSB:`SBAP_G1_LSB];
                next_bus.g1_done = 1'b0;
            end else begin
                next_bus.sub2_addr[`SBAP_ADDR_MSB:`SBAP_G1_LSB] =
                    ~link.addr_n[`SBAP_ADDR_MSB:`SBAP_G1_LSB];
                next_bus.g1_done = 1'b1;
            end
        end
        if (next_bus.g0_done && next_bus.g1_done) begin
            next_bus.g0_done = 1'b0;
            next_bus.g1_done = 1'b0;
            next_bus.busy    = 1'b1;
            next_bus.rx_tgl  = ~bus.rx_tgl;
        end
        // Raised on the capture edge itself, so the next idle cycle sees it
        next_bus.bnr_oe    = next_bus.busy | bus_in_s[0]; // RQ12
        next_bus.bnr_out_n = ~next_bus.bnr_oe; // RQ14
    end

    // Straps are driven from reset until the first edge after release
    always_ff @(posedge link.bus_clk or negedge bus_rst_n) begin
        if (!bus_rst_n) begin
            bus <= BUS_RST;
        end else begin
            bus <= next_bus; // RQ11
        end
    end

    // ----------------------------------------------------------------
    // Core side: hand-over and mask drive
    // ----------------------------------------------------------------
    always_comb begin
        next_core            = core;
        next_core.stall      = stall_req;
        next_core.mask_out_n = ~(mask_req & real_mode); // RQ7
        if (core.rx_valid && rx_ready) begin
            next_core.rx_valid = 1'b0;
            next_core.ack_tgl  = rx_tgl_s;
        end
        if (!core.rx_valid && (rx_tgl_s != core.ack_tgl)) begin
            next_core.rx_valid  = 1'b1;
            next_core.rx_addr   = bus.sub1_addr;
            next_core.rx_attr   = bus.sub2_addr;
            next_core.rx_code_a = bus.sub1_code;
            next_core.rx_code_b = bus.sub2_code;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core <= CORE_RST;
        end else begin
            core <= next_core;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all from flops
    // ----------------------------------------------------------------
    assign rx_valid               = core.rx_valid;
    assign rx_addr                = core.rx_addr;
    assign rx_attr                = core.rx_attr;
    assign rx_code_a              = core.rx_code_a;
    assign rx_code_b              = core.rx_code_b;
    assign link.addr_bit20_mask_n = core.mask_out_n;
    assign link.addr_n_hub        = bus.addr_out_n;
    assign link.addr_oe_hub       = bus.addr_oe;
    assign link.bnr_n_hub         = bus.bnr_out_n;
    assign link.bnr_oe_hub        = bus.bnr_oe;
endmodule : sbap_hub_end
`default_nettype wire

// File: sbap_monitor.sv
// Checker of address phase timing on the shared link.
`timescale 1ns/1ps
`default_nettype none
module sbap_monitor (
    // Link clock and reset
    input wire logic       bus_clk,
    input wire logic       arst_n,
    // Watched link lines
    input wire logic       addr_oe_cpu,
    input wire logic       addr_valid_strobe_n,
    input wire logic [1:0] addr_sample_strobes_n,
    input wire logic       block_next_request_n
);
    // ----------------------------------------------------------------
    // Link timing checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge bus_clk); endclocking
    default disable iff (!arst_n);

    AST_ONE_SUB1: assert property (!addr_valid_strobe_n |=> addr_valid_strobe_n ##1 addr_valid_strobe_n)
        else $error("valid strobe not one cycle or no idle gap");
    AST_STB_SUB1: assert property (!addr_valid_strobe_n |->
        addr_sample_strobes_n != $past(addr_sample_strobes_n))
        else $error("strobes did not change in sub-phase one");
    AST_STB_SUB2: assert property (!addr_valid_strobe_n |=>
        addr_sample_strobes_n != $past(addr_sample_strobes_n))
        else $error("strobes did not change in sub-phase two");
    AST_OE_SUB1: assert property (!addr_valid_strobe_n |-> addr_oe_cpu)
        else $error("address lines not driven in sub-phase one");
    AST_OE_SUB2: assert property (!addr_valid_strobe_n |=> addr_oe_cpu)
        else $error("address lines not driven in sub-phase two");
    AST_NO_ISSUE_STALL: assert property ($fell(addr_valid_strobe_n) |->
        $past(block_next_request_n))
        else $error("transaction issued during stall");
    AST_HUB_BLOCKS: assert property (!addr_valid_strobe_n |-> ##[2:3] !block_next_request_n)
        else $error("stall line not pulled after capture");
    AST_OE_RELEASE: assert property ($rose(addr_valid_strobe_n) |=> !addr_oe_cpu)
        else $error("address lines held after sub-phase two");
endmodule : sbap_monitor
`default_nettype wire

// File: system_bus_address_phase_test.sv
// Bench joining processor end and hub end over the link.
`timescale 1ns/1ps
`default_nettype none
module system_bus_address_phase_test;
    import sbap_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus, instances and scenarios
    // ----------------------------------------------------------------
    localparam sbap_addr_t STRAP = 33'h1_2C3A_5F0E;
    logic       clk = 0, arst_n = 0, req_valid = 0, rx_ready = 0, hub_stall = 0, cpu_stall = 0;
    logic       mask_req = 0, real_mode = 0, req_ready, strap_valid, a20_active, rx_valid;
    sbap_addr_t req_addr = '0, req_attr = '0, strap_value, rx_addr, rx_attr;
    sbap_code_t req_code_a = '0, req_code_b = '0, rx_code_a, rx_code_b;
    int         miscompares = 0, cmp_count = 0, cyc = 0, n;
    sbap_if     lk ();

    // Core clock, and a link clock offset so edges drift apart
    always #4 clk = ~clk;
    initial begin
        lk.bus_clk = 0;
        #1.3;
        forever #3 lk.bus_clk = ~lk.bus_clk;
    end
    sbap_cpu_end sbap_cpu_end_inst (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_addr(req_addr), .req_attr(req_attr),
        .req_code_a(req_code_a), .req_code_b(req_code_b), .stall_req(cpu_stall),
        .strap_value(strap_value), .strap_valid(strap_valid), .a20_active(a20_active), .link(lk));
    sbap_hub_end #(.STRAP_VALUE(STRAP)) sbap_hub_end_inst (.clk(clk), .arst_n(arst_n),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_addr(rx_addr), .rx_attr(rx_attr),
        .rx_code_a(rx_code_a), .rx_code_b(rx_code_b), .stall_req(hub_stall),
        .mask_req(mask_req), .real_mode(real_mode), .link(lk));
    sbap_monitor sbap_monitor_inst (.bus_clk(lk.bus_clk), .arst_n(arst_n),
        .addr_oe_cpu(lk.addr_oe_cpu), .addr_valid_strobe_n(lk.addr_valid_strobe_n),
        .addr_sample_strobes_n(lk.addr_sample_strobes_n),
        .block_next_request_n(lk.block_next_request_n));

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic btick();
        @(posedge lk.bus_clk);
        #1;
    endtask : btick
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    // One transaction; hold keeps the hub stalling before issue
    task automatic xfer(input sbap_addr_t a, input sbap_addr_t t, input sbap_code_t ca,
                        input sbap_code_t cb, input logic hold);
        sbap_addr_t ea;
        ea = a;
        if (mask_req && real_mode)
            ea[20] = 1'b0;
        hub_stall = hold;
        repeat (10) tick();
        if (hold)
            check(lk.block_next_request_n, 1'b0);
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) tick();
        {req_addr, req_attr, req_code_a, req_code_b} = {a, t, ca, cb};
        req_valid = 1;
        tick();
        req_valid = 0;
        // Stall held well past the request sync delay
        repeat (hold ? 30 : 0) begin
            btick();
            check(lk.addr_valid_strobe_n, 1'b1);
        end
        hub_stall = 0;
        for (n = 0; n < 200 && lk.addr_valid_strobe_n !== 1'b0; n++) btick();
        check(lk.addr_n, sbap_addr_t'(~ea));
        check(lk.req_code_n, sbap_code_t'(~ca));
        btick();
        check(lk.addr_n, sbap_addr_t'(~t));
        check(lk.req_code_n, sbap_code_t'(~cb));
        for (n = 0; n < 100 && rx_valid !== 1'b1; n++) tick();
        check(rx_valid, 1'b1);
        check(rx_addr, ea);
        check(rx_attr, t);
        check({rx_code_a, rx_code_b}, {ca, cb});
        check(lk.block_next_request_n, 1'b0);
        rx_ready = 1;
        tick();
        rx_ready = 0;
    endtask : xfer

    // Mask pin follows the hub only in real mode
    task automatic t_mask(input logic m, input logic r);
        mask_req = m;
        real_mode = r;
        repeat (8) tick();
        check(lk.addr_bit20_mask_n, !(m && r));
        check(a20_active, m && r);
    endtask : t_mask

    // Processor end drives the stall line
    task automatic t_cpu_stall();
        cpu_stall = 1;
        repeat (6) tick();
        check(lk.block_next_request_n, 1'b0);
        cpu_stall = 0;
        repeat (6) tick();
        check(lk.block_next_request_n, 1'b1);
    endtask : t_cpu_stall

    // Hang guard, far above the longest scenario
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        #1 arst_n = 1;
        for (n = 0; n < 50 && strap_valid !== 1'b1; n++) tick();
        check(strap_valid, 1'b1);
        check(strap_value, STRAP);
        xfer(33'h1_2345_6789, 33'h0_DCBA_9876, 5'h15, 5'h0A, 1'b0);
        xfer(33'h0_0010_0000, 33'h1_FFFF_FFFF, 5'h1F, 5'h00, 1'b0);
        t_mask(1'b1, 1'b0);
        t_mask(1'b1, 1'b1);
        xfer(33'h1_2347_6789, 33'h0_0000_0001, 5'h0A, 5'h15, 1'b0);
        t_mask(1'b0, 1'b1);
        xfer(33'h0_7FF0_0008, 33'h1_0F0F_0F0F, 5'h03, 5'h1C, 1'b1);
        t_cpu_stall();
        close_out();
    end
endmodule : system_bus_address_phase_test
`default_nettype wire
